// ===== tpc_consts.svh
// Constants for the task protection and context unit.
// Assumes a 64-bit core word; included by the package, the table, the unit and the bench.
`ifndef TPC_CONSTS_SVH
`define TPC_CONSTS_SVH
`define TPC_XLEN 64
`define TPC_NENT 32
`define TPC_NFENCE 2
`define TPC_OFF_4K 6'h0C
`define TPC_OFF_32K 6'h0F
`define TPC_OFF_256K 6'h12
`define TPC_OFF_2M 6'h15
`define TPC_OFF_FENCE 6'h11
`define TPC_AT_SZ 0
`define TPC_AT_CACHE 2
`define TPC_AT_RD 3
`define TPC_AT_WR 4
`define TPC_AT_VALID 5
`define TPC_AT_FLOG 8
`define TPC_AT_TAG 16
`define TPC_AT_USE 32
`define TPC_CAP_W 8
`define TPC_CAP_BYPASS 0
`define TPC_CAP_CTX 1
`define TPC_CAP_MISS 2
`define TPC_CAP_RST 8'hFF
`define TPC_MSW_STEP 0
`define TPC_MSW_TAG 16
`define TPC_SR_MSW 16'h0001
`define TPC_SR_CAPS 16'h0002
`define TPC_SR_NEXT 16'h0003
`define TPC_SR_CTX 16'h0004
`define TPC_SR_MISS 16'h0005
`define TPC_SR_TIDX 16'h0010
`define TPC_SR_TVA 16'h0011
`define TPC_SR_TPA 16'h0012
`define TPC_SR_TAT 16'h0013
`define TPC_SR_SLICE 16'h0020
`define TPC_SLOT_IP 7'h00
`define TPC_SLOT_NEXT 7'h40
`define TPC_SLOT_SLICE 7'h41
`endif

// ===== tpc_pkg.sv
// Types shared by the task protection and context unit.
// Assumes tpc_consts.svh is on the include path.
`include "tpc_consts.svh"
package tpc_pkg;
   typedef logic [`TPC_XLEN-1:0] tpc_word_t;
   typedef enum logic [2:0] {
      st_run = 3'h0, st_save = 3'h1, st_next = 3'h3,
      st_slice = 3'h2, st_ip = 3'h6, st_bkp = 3'h7
   } tpc_state_e;
   typedef enum logic [2:0] {
      tr_none = 3'h0, tr_miss = 3'h1, tr_perm = 3'h2,
      tr_sreg = 3'h3, tr_step = 3'h4
   } tpc_trap_e;
   typedef enum logic [1:0] {
      pg_4k = 2'h0, pg_32k = 2'h1, pg_256k = 2'h2, pg_2m = 2'h3
   } tpc_pgsz_e;
endpackage

// ===== tpc_tlb_if.sv
// Carrier between the control unit and the translation table.
// Assumes a single clock; all signals are same-domain.
`timescale 1ns/100ps
interface tpc_tlb_if;
   import tpc_pkg::*;
   tpc_word_t lk_addr;
   logic [15:0] lk_tag;
   logic lk_upd;
   logic lk_hit;
   logic lk_cache;
   logic lk_rd;
   logic lk_wr;
   tpc_word_t lk_phys;
   logic wr_en;
   logic [5:0] wr_idx;
   tpc_word_t wr_va;
   tpc_word_t wr_pa;
   tpc_word_t wr_at;
   logic [5:0] rd_idx;
   tpc_word_t rd_at;
   modport ctl(output lk_addr, lk_tag, lk_upd, wr_en, wr_idx, wr_va,
      wr_pa, wr_at, rd_idx, input lk_hit, lk_cache, lk_rd, lk_wr,
      lk_phys, rd_at);
   modport tbl(input lk_addr, lk_tag, lk_upd, wr_en, wr_idx, wr_va,
      wr_pa, wr_at, rd_idx, output lk_hit, lk_cache, lk_rd, lk_wr,
      lk_phys, rd_at);
endinterface

// ===== tpc_tlb.sv
// Software-loaded translation table: pages plus fence descriptors.
// Assumes the control unit writes entries and registers lookup results.
`timescale 1ns/100ps
`include "tpc_consts.svh"
module tpc_tlb
   import tpc_pkg::*;
#(
   parameter int NENT = `TPC_NENT,
   parameter int NFENCE = `TPC_NFENCE
) (
   input wire logic clock,
   input wire logic sys_rst,
   tpc_tlb_if.tbl tb
);
   localparam int NT = NENT + NFENCE;
   tpc_word_t va_r [NT];
   tpc_word_t pa_r [NT];
   tpc_word_t at_r [NT];
   tpc_word_t phys_c [NT];
   logic [2:0] csel_c [NT];
   logic [NT-1:0] hit;
   logic [5:0] sel;

   for (genvar i = 0; i < NT; i++) begin : g_ent
      logic [5:0] off;
      logic [5:0] flog;
      tpc_word_t msk;
      assign flog = at_r[i][`TPC_AT_FLOG +: 6];
      always_comb begin
         if (i >= NENT) begin
            // Fences below the 128KB grain are widened to it
            off = (flog < `TPC_OFF_FENCE) ? `TPC_OFF_FENCE : flog;
         end else begin
            unique case (tpc_pgsz_e'(at_r[i][`TPC_AT_SZ +: 2]))
               pg_4k: off = `TPC_OFF_4K;
               pg_32k: off = `TPC_OFF_32K;
               pg_256k: off = `TPC_OFF_256K;
               pg_2m: off = `TPC_OFF_2M;
            endcase
         end
      end
      assign msk = ~((64'h1 << off) - 64'h1);
      assign hit[i] = at_r[i][`TPC_AT_VALID] &&
         at_r[i][`TPC_AT_TAG +: 16] == tb.lk_tag &&
         ((tb.lk_addr ^ va_r[i]) & msk) == 64'h0;
      assign phys_c[i] = (pa_r[i] & msk) | (tb.lk_addr & ~msk);
      assign csel_c[i] = 3'(tb.lk_addr >> (off - 6'h03));
   end

   // Lowest index wins when software leaves overlapping entries
   always_comb begin
      sel = 6'h00;
      for (int k = NT - 1; k >= 0; k--) begin
         if (hit[k]) sel = 6'(k);
      end
   end

   assign tb.lk_hit = |hit;
   assign tb.lk_phys = phys_c[sel];
   assign tb.lk_cache = at_r[sel][`TPC_AT_CACHE];
   assign tb.lk_rd = at_r[sel][`TPC_AT_RD];
   assign tb.lk_wr = at_r[sel][`TPC_AT_WR];
   assign tb.rd_at = (tb.rd_idx < NT) ? at_r[tb.rd_idx] : 64'h0;

   always_ff @(posedge clock) begin
      if (tb.wr_en && tb.wr_idx < NT) begin
         va_r[tb.wr_idx] <= tb.wr_va;
         pa_r[tb.wr_idx] <= tb.wr_pa;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         for (int k = 0; k < NT; k++) at_r[k] <= 64'h0;
      end else if (tb.wr_en && tb.wr_idx < NT) begin
         at_r[tb.wr_idx] <= tb.wr_at;
      end else if (tb.lk_upd && tb.lk_hit && sel < NENT) begin
         if (at_r[sel][`TPC_AT_USE + 2 * csel_c[sel] +: 2] != 2'h3) begin
            at_r[sel][`TPC_AT_USE + 2 * csel_c[sel] +: 2] <=
               at_r[sel][`TPC_AT_USE + 2 * csel_c[sel] +: 2] + 2'h1;
         end
      end
   end
endmodule

// ===== tpc_unit.sv
// Task protection and context unit: access checks, special registers,
// capability gating and automatic context-block task switching.
// Assumes the pipeline stalls on hold and presents accesses one a cycle.
`timescale 1ns/100ps
`include "tpc_consts.svh"
module tpc_unit
   import tpc_pkg::*;
#(
   parameter int NENT = `TPC_NENT,
   parameter int NFENCE = `TPC_NFENCE
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic retire,
   input wire tpc_word_t retire_ip,
   input wire logic rft_op,
   output logic hold,
   output logic resume,
   output tpc_word_t resume_ip,
   input wire logic acc_valid,
   input wire logic acc_write,
   input wire tpc_word_t acc_addr,
   output logic acc_done,
   output tpc_word_t acc_phys,
   output logic acc_cacheable,
   input wire logic sr_valid,
   input wire logic sr_write,
   input wire logic [15:0] sr_num,
   input wire tpc_word_t sr_wdata,
   output logic sr_done,
   output tpc_word_t sr_rdata,
   output logic trap,
   output logic [2:0] trap_cause,
   output tpc_word_t miss_handler,
   output logic single_step,
   output logic mem_valid,
   output logic mem_write,
   output tpc_word_t mem_addr,
   output tpc_word_t mem_wdata,
   input wire logic mem_ready,
   input wire logic mem_rvalid,
   input wire tpc_word_t mem_rdata,
   output logic bkp_start,
   output tpc_word_t bkp_old_ctx,
   output tpc_word_t bkp_new_ctx,
   input wire logic bkp_done
);
   tpc_tlb_if tb ();
   tpc_state_e state_r;
   tpc_state_e state_nxt;
   tpc_trap_e cause_r;
   tpc_trap_e cause_nxt;
   tpc_word_t msw_r;
   tpc_word_t next_ctx_r;
   tpc_word_t ctx_ptr_r;
   tpc_word_t miss_r;
   tpc_word_t tgt_r;
   tpc_word_t tva_r;
   tpc_word_t tpa_r;
   tpc_word_t slice_r;
   tpc_word_t addr_r;
   tpc_word_t addr_nxt;
   tpc_word_t wdata_r;
   tpc_word_t rip_r;
   tpc_word_t srd_r;
   tpc_word_t srd_nxt;
   tpc_word_t phys_r;
   logic [5:0] tidx_r;
   logic [`TPC_CAP_W-1:0] caps_r;
   logic slice_en_r;
   logic issued_r;
   logic bkp_r;
   logic resume_r;
   logic trap_r;
   logic sr_done_r;
   logic acc_done_r;
   logic cache_r;
   logic sr_ok;
   logic sr_fire;
   logic wr_fire;
   logic bypass;
   logic miss;
   logic perm;
   logic step;
   logic slice_out;
   logic switch_go;
   logic rd_back;

   function automatic tpc_word_t slot_adr(input tpc_word_t base,
      input logic [6:0] slot);
      return base + {54'h0, slot, 3'h0};
   endfunction

   tpc_tlb #(
      .NENT(NENT),
      .NFENCE(NFENCE)
   ) u_tlb (
      .clock(clock),
      .sys_rst(sys_rst),
      .tb(tb)
   );

   assign hold = state_r != st_run;
   assign resume = resume_r;
   assign resume_ip = rip_r;
   assign acc_done = acc_done_r;
   assign acc_phys = phys_r;
   assign acc_cacheable = cache_r;
   assign sr_done = sr_done_r;
   assign sr_rdata = srd_r;
   assign trap = trap_r;
   assign trap_cause = cause_r;
   assign miss_handler = miss_r;
   assign single_step = msw_r[`TPC_MSW_STEP];
   assign mem_addr = addr_r;
   assign mem_wdata = wdata_r;
   assign bkp_start = bkp_r;
   assign bkp_old_ctx = ctx_ptr_r;
   assign bkp_new_ctx = tgt_r;

   // Special register decode and permission
   always_comb begin
      case (sr_num)
         `TPC_SR_MSW: sr_ok = 1'b1;
         `TPC_SR_CAPS, `TPC_SR_NEXT, `TPC_SR_CTX:
            sr_ok = caps_r[`TPC_CAP_CTX];
         `TPC_SR_MISS, `TPC_SR_TIDX, `TPC_SR_TVA, `TPC_SR_TPA, `TPC_SR_TAT:
            sr_ok = caps_r[`TPC_CAP_MISS];
         `TPC_SR_SLICE: sr_ok = !sr_write;
         default: sr_ok = 1'b0;
      endcase
   end

   always_comb begin
      case (sr_num)
         `TPC_SR_MSW: srd_nxt = msw_r;
         `TPC_SR_CAPS: srd_nxt = tpc_word_t'(caps_r);
         `TPC_SR_NEXT: srd_nxt = next_ctx_r;
         `TPC_SR_CTX: srd_nxt = ctx_ptr_r;
         `TPC_SR_MISS: srd_nxt = miss_r;
         `TPC_SR_TIDX: srd_nxt = tpc_word_t'(tidx_r);
         `TPC_SR_TVA: srd_nxt = tva_r;
         `TPC_SR_TPA: srd_nxt = tpa_r;
         `TPC_SR_TAT: srd_nxt = tb.rd_at;
         `TPC_SR_SLICE: srd_nxt = slice_r;
         default: srd_nxt = 64'h0;
      endcase
   end

   assign sr_fire = sr_valid && sr_ok;
   assign wr_fire = sr_fire && sr_write;

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         sr_done_r <= 1'b0;
         srd_r <= 64'h0;
      end else begin
         sr_done_r <= sr_fire;
         if (sr_fire) srd_r <= srd_nxt;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         msw_r <= 64'h0;
      end else if (wr_fire && sr_num == `TPC_SR_MSW) begin
         msw_r <= sr_wdata;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         caps_r <= `TPC_CAP_RST;
      end else if (wr_fire && sr_num == `TPC_SR_CAPS) begin
         caps_r <= sr_wdata[`TPC_CAP_W-1:0];
      end
   end

   // Hardware reload of next-context only happens while hold is high,
   // so it cannot collide with a software write
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         next_ctx_r <= 64'h0;
      end else if (state_r == st_next && rd_back) begin
         next_ctx_r <= mem_rdata;
      end else if (wr_fire && sr_num == `TPC_SR_NEXT) begin
         next_ctx_r <= sr_wdata;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         ctx_ptr_r <= 64'h0;
      end else if (state_r == st_bkp && bkp_done) begin
         ctx_ptr_r <= tgt_r;
      end else if (wr_fire && sr_num == `TPC_SR_CTX) begin
         ctx_ptr_r <= sr_wdata;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         miss_r <= 64'h0;
      end else if (wr_fire && sr_num == `TPC_SR_MISS) begin
         miss_r <= sr_wdata;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         tidx_r <= 6'h00;
         tva_r <= 64'h0;
         tpa_r <= 64'h0;
      end else if (wr_fire) begin
         if (sr_num == `TPC_SR_TIDX) tidx_r <= sr_wdata[5:0];
         if (sr_num == `TPC_SR_TVA) tva_r <= sr_wdata;
         if (sr_num == `TPC_SR_TPA) tpa_r <= sr_wdata;
      end
   end

   // Writing the attribute word commits the staged entry
   assign tb.wr_en = wr_fire && sr_num == `TPC_SR_TAT;
   assign tb.wr_idx = tidx_r;
   assign tb.wr_va = tva_r;
   assign tb.wr_pa = tpa_r;
   assign tb.wr_at = sr_wdata;
   assign tb.rd_idx = tidx_r;

   // Access check
   assign bypass = caps_r[`TPC_CAP_BYPASS];
   assign tb.lk_addr = acc_addr;
   assign tb.lk_tag = msw_r[`TPC_MSW_TAG +: 16];
   assign miss = !bypass && !tb.lk_hit;
   assign perm = !bypass && tb.lk_hit &&
      (acc_write ? !tb.lk_wr : !tb.lk_rd);
   assign tb.lk_upd = acc_valid && !bypass && !miss && !perm;

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         acc_done_r <= 1'b0;
         phys_r <= 64'h0;
         cache_r <= 1'b0;
      end else begin
         acc_done_r <= acc_valid && !miss && !perm;
         if (acc_valid && !miss && !perm) begin
            phys_r <= bypass ? acc_addr : tb.lk_phys;
            cache_r <= bypass || tb.lk_cache;
         end
      end
   end

   // Trap selection: access faults outrank register faults and stepping
   assign step = retire && msw_r[`TPC_MSW_STEP];
   assign cause_nxt = (acc_valid && miss) ? tr_miss :
      (acc_valid && perm) ? tr_perm :
      (sr_valid && !sr_ok) ? tr_sreg :
      step ? tr_step : tr_none;

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         trap_r <= 1'b0;
         cause_r <= tr_none;
      end else begin
         trap_r <= cause_nxt != tr_none;
         if (cause_nxt != tr_none) cause_r <= cause_nxt;
      end
   end

   // Time slice; a slot value of zero disables automatic switching
   assign slice_out = slice_en_r && slice_r == 64'h0;
   assign switch_go = state_r == st_run && retire &&
      (rft_op || slice_out);

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         slice_r <= 64'h0;
         slice_en_r <= 1'b0;
      end else if (state_r == st_slice && rd_back) begin
         slice_r <= mem_rdata;
         slice_en_r <= |mem_rdata;
      end else if (state_r == st_run && slice_en_r && slice_r != 64'h0) begin
         slice_r <= slice_r - 64'h1;
      end
   end

   // Switch sequencer
   assign rd_back = issued_r && mem_rvalid;
   assign mem_valid = !issued_r && (state_r == st_save ||
      state_r == st_next || state_r == st_slice || state_r == st_ip);
   assign mem_write = state_r == st_save;

   always_comb begin
      state_nxt = state_r;
      addr_nxt = addr_r;
      unique case (state_r)
         st_run: if (switch_go) begin
            state_nxt = st_save;
            addr_nxt = slot_adr(ctx_ptr_r, `TPC_SLOT_IP);
         end
         st_save: if (mem_valid && mem_ready) begin
            state_nxt = st_next;
            addr_nxt = slot_adr(tgt_r, `TPC_SLOT_NEXT);
         end
         st_next: if (rd_back) begin
            state_nxt = st_slice;
            addr_nxt = slot_adr(tgt_r, `TPC_SLOT_SLICE);
         end
         st_slice: if (rd_back) begin
            state_nxt = st_ip;
            addr_nxt = slot_adr(tgt_r, `TPC_SLOT_IP);
         end
         st_ip: if (rd_back) begin
            state_nxt = st_bkp;
         end
         st_bkp: if (bkp_done) begin
            state_nxt = st_run;
         end
         default: state_nxt = st_run;
      endcase
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= st_run;
         addr_r <= 64'h0;
         issued_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         addr_r <= addr_nxt;
         issued_r <= (state_nxt != state_r) ? 1'b0 :
            issued_r || (mem_valid && mem_ready);
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         tgt_r <= 64'h0;
         wdata_r <= 64'h0;
         rip_r <= 64'h0;
         bkp_r <= 1'b0;
         resume_r <= 1'b0;
      end else begin
         bkp_r <= state_r == st_ip && rd_back;
         resume_r <= state_r == st_bkp && bkp_done;
         if (switch_go) begin
            tgt_r <= next_ctx_r;
            wdata_r <= retire_ip;
         end
         if (state_r == st_ip && rd_back) rip_r <= mem_rdata;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   a_miss_trap: assert property (
      acc_valid && !bypass && !tb.lk_hit |=>
      trap && trap_cause == tr_miss && !acc_done)
      else $error("missing entry did not trap");
   a_perm_trap: assert property (
      acc_valid && perm |=> trap && trap_cause == tr_perm && !acc_done)
      else $error("permission fault did not trap");
   a_bypass_phys: assert property (
      acc_valid && bypass |=> acc_done && acc_phys == $past(acc_addr))
      else $error("bypass did not pass address through");
   a_ctx_gate: assert property (
      sr_valid && sr_num == `TPC_SR_CTX && !caps_r[`TPC_CAP_CTX] |=>
      !sr_done && ctx_ptr_r == $past(ctx_ptr_r))
      else $error("context pointer reached without capability");
   a_miss_gate: assert property (
      sr_valid && sr_write && sr_num == `TPC_SR_MISS &&
      caps_r[`TPC_CAP_MISS] |=> sr_done && miss_handler == $past(sr_wdata))
      else $error("miss handler write lost");
   a_caps_reset: assert property (
      $past(sys_rst) |-> caps_r == `TPC_CAP_RST)
      else $error("capabilities not all set after reset");
   a_sr_bad: assert property (
      sr_valid && sr_num == 16'hFFFF && !acc_valid |=>
      trap && trap_cause == tr_sreg && !sr_done)
      else $error("unknown special register did not trap");
   a_step_trap: assert property (
      retire && single_step && !acc_valid && !sr_valid |=>
      trap && trap_cause == tr_step)
      else $error("single step trap missing");
   a_slice_count: assert property (
      state_r == st_run && slice_en_r && slice_r != 64'h0 |=>
      slice_r == $past(slice_r) - 64'h1)
      else $error("time slice did not count down");
   a_switch_seq: assert property (
      switch_go |=> hold && mem_valid && mem_write &&
      mem_addr == $past(ctx_ptr_r) && tgt_r == $past(next_ctx_r) &&
      mem_wdata == $past(retire_ip))
      else $error("switch did not start with saving the pointer");
   a_next_load: assert property (
      state_r == st_next && rd_back |=> next_ctx_r == $past(mem_rdata) &&
      mem_addr == slot_adr(tgt_r, `TPC_SLOT_SLICE))
      else $error("next slot not copied on entry");

   c_rft_switch: cover property (rft_op && switch_go ##[1:200] resume);
   c_slice_switch: cover property (slice_out && switch_go);
   c_step_trap: cover property (trap && trap_cause == tr_step);
   c_miss_trap: cover property (trap && trap_cause == tr_miss);
endmodule

// ===== tpc_pipe_model.sv
// Far-side model: context-block memory and the background register saver.
// Assumes the unit holds each memory request until mem_ready is sampled.
`timescale 1ns/100ps
module tpc_pipe_model
   import tpc_pkg::*;
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic slow,
   input wire logic mem_valid,
   input wire logic mem_write,
   input wire tpc_word_t mem_addr,
   input wire tpc_word_t mem_wdata,
   output logic mem_ready,
   output logic mem_rvalid,
   output tpc_word_t mem_rdata,
   input wire logic bkp_start,
   output logic bkp_done,
   output tpc_word_t wr_addr,
   output tpc_word_t wr_data
);
   tpc_word_t mem [tpc_word_t];
   logic tick;
   logic [1:0] bcnt;
   always @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         mem_ready <= 1'b0;
         mem_rvalid <= 1'b0;
         mem_rdata <= '0;
         bkp_done <= 1'b0;
         bcnt <= 2'h0;
         tick <= 1'b0;
         wr_addr <= '0;
         wr_data <= '0;
      end else begin
         tick <= ~tick;
         mem_ready <= mem_valid && !mem_ready && (!slow || tick);
         mem_rvalid <= 1'b0;
         // Stale read data flips so it never passes for a fresh word
         mem_rdata <= ~mem_rdata;
         if (mem_valid && mem_ready) begin
            if (mem_write) begin
               mem[mem_addr] = mem_wdata;
               wr_addr <= mem_addr;
               wr_data <= mem_wdata;
            end else begin
               mem_rvalid <= 1'b1;
               mem_rdata <= mem[mem_addr];
            end
         end
         bkp_done <= (bcnt == 2'h1);
         if (bkp_start) begin
            bcnt <= 2'h3;
         end else if (bcnt != 2'h0) begin
            bcnt <= bcnt - 2'h1;
         end
      end
   end
endmodule

// ===== tb_task_protection_context_unit.sv
// Self-checking bench for the task protection and context unit.
// Assumes tpc_pipe_model answers memory and saver requests.
`timescale 1ns/100ps
`include "tpc_consts.svh"
module tb_task_protection_context_unit import tpc_pkg::*;;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic retire = 1'b0, rft_op = 1'b0, acc_valid = 1'b0, acc_write = 1'b0;
   logic sr_valid = 1'b0, sr_write = 1'b0, slow = 1'b0;
   logic [15:0] sr_num = 16'h0000;
   tpc_word_t retire_ip = '0, acc_addr = '0, sr_wdata = '0;
   logic hold, resume, acc_done, acc_cacheable, sr_done, trap, single_step;
   logic mem_valid, mem_write, mem_ready, mem_rvalid, bkp_start, bkp_done;
   logic [2:0] trap_cause, c, ec;
   tpc_word_t resume_ip, acc_phys, sr_rdata, miss_handler, mem_addr;
   tpc_word_t mem_wdata, mem_rdata, wr_addr, wr_data, q, a, off, m;
   tpc_word_t bkp_old_ctx, bkp_new_ctx, ob, nb;
   // Entries 0..2 are 4KB, 2MB and 32KB pages; the last one is a fence
   tpc_word_t va [4] = '{64'h4000_0000, 64'h5000_0000, 64'h7000_0000,
      64'h6000_0000};
   tpc_word_t pa [4] = '{64'h8000_0000, 64'h9000_0000, 64'hA000_0000,
      64'hB000_0000};
   logic [5:0] at [4] = '{6'h2C, 6'h3B, 6'h29, 6'h28};
   logic [15:0] use_e [2] = '{16'h0000, 16'h0000};
   logic [31:0] rs = 32'h0000A2C7;
   logic [31:0] r;
   int bad_count = 0, check_count = 0, cyc = 0, e, sh;
   always #4 clock = ~clock;
   tpc_unit u_dut (.clock, .sys_rst, .retire, .retire_ip, .rft_op, .hold,
      .resume, .resume_ip, .acc_valid, .acc_write, .acc_addr, .acc_done,
      .acc_phys, .acc_cacheable, .sr_valid, .sr_write, .sr_num, .sr_wdata,
      .sr_done, .sr_rdata, .trap, .trap_cause, .miss_handler, .single_step,
      .mem_valid, .mem_write, .mem_addr, .mem_wdata, .mem_ready,
      .mem_rvalid, .mem_rdata, .bkp_start, .bkp_old_ctx, .bkp_new_ctx,
      .bkp_done);
   tpc_pipe_model u_mem (.clock, .sys_rst, .slow, .mem_valid, .mem_write,
      .mem_addr, .mem_wdata, .mem_ready, .mem_rvalid, .mem_rdata,
      .bkp_start, .bkp_done, .wr_addr, .wr_data);
   function automatic logic [31:0] xs();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction
   function automatic logic [2:0] ecause(input logic miss, wr, hi);
      return miss ? 3'h1 : (wr && !hi) ? 3'h2 : 3'h0;
   endfunction
   task automatic chk(input tpc_word_t s, input tpc_word_t x);
      check_count++;
      if (s !== x) begin
         bad_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
      end
   endtask
   task automatic summarize();
      $display("checks=%0d mismatches=%0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // One request, SR when k is 0, access when 1; c gets the trap cause
   task automatic op(input logic k, input logic wr, input tpc_word_t x,
      input tpc_word_t d);
      // Idle edge first, so a strobe is never re-driven in one time step
      @(posedge clock);
      #1;
      sr_valid = ~k;
      acc_valid = k;
      sr_write = wr;
      acc_write = wr;
      sr_num = x[15:0];
      acc_addr = x;
      sr_wdata = d;
      c = 3'h7;
      for (int i = 0; i < 4 && c == 3'h7; i++) begin
         @(posedge clock);
         #1;
         sr_valid = 1'b0;
         acc_valid = 1'b0;
         if (trap === 1'b1) c = trap_cause;
         else if (sr_done === 1'b1 || acc_done === 1'b1) c = 3'h0;
      end
      q = k ? acc_phys : sr_rdata;
   endtask
   task automatic ret(input logic f, input tpc_word_t ip);
      retire = 1'b1;
      rft_op = f;
      retire_ip = ip;
      @(posedge clock);
      #1;
      retire = 1'b0;
      rft_op = 1'b0;
   endtask
   task automatic wt(input logic s, input int n);
      for (int i = 0; i < n && (s ? resume : trap) !== 1'b1; i++) begin
         @(posedge clock);
         #1;
      end
   endtask
   always @(posedge clock) begin
      if (bkp_start === 1'b1) ob <= bkp_old_ctx;
      if (bkp_start === 1'b1) nb <= bkp_new_ctx;
   end
   always @(posedge clock) begin
      cyc++;
      if (cyc == 6000) begin
         bad_count++;
         summarize();
      end
   end
   initial begin
      repeat (8) @(posedge clock);
      #1;
      sys_rst = 1'b0;
      op(0, 0, `TPC_SR_CAPS, '0);
      chk(q, 64'hFF);
      op(1, 0, 64'h1234_5678, '0);
      chk(c, 3'h0);
      chk(acc_cacheable, 1'b1);
      op(0, 1, `TPC_SR_MSW, 64'h1);
      wt(1'b0, 1);
      chk(single_step, 1'b1);
      ret(1'b0, 64'h44);
      wt(1'b0, 4);
      chk(trap_cause, 3'h4);
      op(0, 1, `TPC_SR_MSW, '0);
      // Debugger-style setup: block A runs five cycles, then hands to B
      u_mem.mem[64'h1000] = 64'h40_0000;
      u_mem.mem[64'h1200] = 64'h2000;
      u_mem.mem[64'h1208] = 64'h5;
      u_mem.mem[64'h2000] = 64'h50_0000;
      u_mem.mem[64'h2200] = 64'h2000;
      u_mem.mem[64'h2208] = 64'h0;
      op(0, 1, `TPC_SR_NEXT, 64'h1000);
      ret(1'b1, 64'hABC);
      wt(1'b1, 300);
      chk(resume_ip, 64'h40_0000);
      chk(wr_data, 64'hABC);
      chk(nb, 64'h1000);
      ret(1'b0, 64'h58);
      chk(hold, 1'b0);
      op(0, 0, `TPC_SR_NEXT, '0);
      chk(q, 64'h2000);
      wt(1'b0, 10);
      slow = 1'b1;
      ret(1'b0, 64'h77);
      chk(hold, 1'b1);
      wt(1'b1, 300);
      chk(resume_ip, 64'h50_0000);
      chk(wr_addr, 64'h1000);
      chk(ob, 64'h1000);
      chk(nb, 64'h2000);
      op(0, 0, `TPC_SR_CTX, '0);
      chk(q, 64'h2000);
      for (e = 0; e < 4; e++) begin
         op(0, 1, `TPC_SR_TIDX, 64'((e == 3) ? 32 : e));
         op(0, 1, `TPC_SR_TVA, va[e]);
         op(0, 1, `TPC_SR_TPA, pa[e]);
         op(0, 1, `TPC_SR_TAT, {58'h0, at[e]});
      end
      op(0, 1, `TPC_SR_CAPS, 64'hFE);
      op(0, 1, `TPC_SR_MSW, 64'h1_0000);
      op(1, 0, va[0], '0);
      chk(c, 3'h1);
      op(0, 1, `TPC_SR_MSW, '0);
      for (int i = 0; i < 24; i++) begin
         r = xs();
         e = int'(r[0]);
         m = e ? 64'h1F_FFFF : 64'hFFF;
         off = (i == 0) ? m : {32'h0, xs()} & m;
         a = va[e] + ((r[2:1] == 2'h3) ? m + 64'h1 : '0) + off;
         ec = ecause(r[2:1] == 2'h3, r[3], r[0]);
         op(1, r[3], a, '0);
         chk(c, ec);
         if (ec == 3'h0) begin
            chk(q, pa[e] | off);
            chk(acc_cacheable, r[0] == 1'b0);
            sh = 2 * int'((a >> (e ? 18 : 9)) & 64'h7);
            if (use_e[e][sh +: 2] != 2'h3) use_e[e][sh +: 2] += 2'h1;
         end
      end
      op(1, 0, 64'h7000_7FF8, '0);
      chk(q, 64'hA000_7FF8);
      op(1, 0, 64'h7000_8000, '0);
      chk(c, 3'h1);
      // Fence size field of zero must act as the 128KB grain
      op(1, 0, 64'h6001_FFF0, '0);
      chk(q, 64'hB001_FFF0);
      op(1, 0, 64'h6002_0000, '0);
      chk(c, 3'h1);
      for (e = 0; e < 2; e++) begin
         op(0, 1, `TPC_SR_TIDX, 64'(e));
         op(0, 0, `TPC_SR_TAT, '0);
         chk(q, {16'h0, use_e[e], 26'h0, at[e]});
      end
      op(0, 0, 64'hFFFF, '0);
      chk(c, 3'h3);
      op(0, 1, `TPC_SR_SLICE, '0);
      chk(c, 3'h3);
      op(0, 1, `TPC_SR_MISS, 64'h7700);
      chk(miss_handler, 64'h7700);
      op(0, 1, `TPC_SR_CAPS, 64'hFA);
      op(0, 0, `TPC_SR_MISS, '0);
      chk(c, 3'h3);
      op(0, 1, `TPC_SR_CAPS, 64'hF8);
      op(0, 0, `TPC_SR_CTX, '0);
      chk(c, 3'h3);
      op(0, 0, `TPC_SR_MSW, '0);
      chk(c, 3'h0);
      summarize();
   end
endmodule
